// file: design/sfsc_pkg.sv
// Purpose: Shared constants of the serial port frame sync control block
// Assumes: Byte addresses on a 4-bit register port, 32-bit data
// Notes:   Offsets, field positions, reset values and sizes of the design live here; the bench keeps its own control field masks
package sfsc_pkg;
  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
  localparam logic [3:0]  ADDR_AUDIO     = 4'h4;
  localparam logic [3:0]  ADDR_DATA      = 4'h8;
  localparam logic [3:0]  ADDR_STATUS    = 4'hC;
  // --------------------------------------------------------------------
  // Control word fields
  // --------------------------------------------------------------------
  localparam int          BIT_FRAMING    = 31;
  localparam int          BIT_SYNC_DIR   = 30;
  localparam int          BIT_SYNC_POL   = 29;
  localparam int          BIT_AUTO_SEL   = 28;
  localparam int          BIT_SYNC_WIDTH = 27;
  localparam int          BIT_GROUP_HI   = 26;
  localparam int          BIT_GROUP_LO   = 24;
  localparam int          BIT_BAUD_SRC   = 23;
  localparam int          BIT_PORT_ON    = 15;
  localparam int          BIT_CLK_EDGE   = 8;
  localparam int          BIT_IDLE_POL   = 6;
  localparam int          BIT_MASTER     = 5;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_WR_MASK   = 32'hFF00_8160;
  localparam logic [31:0] CTRL_RD_MASK   = 32'hFF80_8160;
  localparam logic [2:0]  GROUP_MAX_CODE = 3'h5;
  // --------------------------------------------------------------------
  // Status and audio word fields
  // --------------------------------------------------------------------
  localparam int          ST_EMPTY       = 0;
  localparam int          ST_FULL        = 1;
  localparam int          ST_LEVEL_LO    = 2;
  localparam int          ST_GROUP_LO    = 8;
  localparam int          ST_BUSY        = 16;
  localparam int          ST_OVERFLOW    = 17;
  localparam int          BIT_AUDIO_EN   = 0;
  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int          CHAR_BITS      = 8;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          LEVEL_BITS     = 5;
  localparam int          GROUP_BITS     = 5;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
endpackage

// file: design/sfsc_fifo_if.sv
// Purpose: Carries the transmit buffer handshake between top and FIFO
// Assumes: Single clock domain
// Notes:   Level counts every word held, output register included
`timescale 1ns/1ns
interface sfsc_fifo_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
);
  logic                       in_valid;
  logic                       in_ready;
  logic [WIDTH-1:0]           in_data;
  logic                       out_valid;
  logic                       out_ready;
  logic [WIDTH-1:0]           out_data;
  logic [$clog2(DEPTH+1)-1:0] level;

  modport user  (output in_valid, in_data, out_ready,
                 input  in_ready, out_valid, out_data, level);
  modport store (input  in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data, level);
endinterface

// file: design/sfsc_fifo.sv
// Purpose: Transmit word buffer with registered read data
// Assumes: DEPTH is a power of two
// Notes:   in_ready falls once DEPTH words are held, output register included
`timescale 1ns/1ns
module sfsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic    clock,
  input wire logic    rst_b,
  sfsc_fifo_if.store  bus
);
  localparam int             AW       = $clog2(DEPTH);
  localparam logic [AW:0]    FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic [WIDTH-1:0]            out_data;
    logic                        out_valid;
  } sfsc_fifo_state_s;

  sfsc_fifo_state_s st_ff;
  sfsc_fifo_state_s nxt_st;
  logic             push;
  logic             load;

  // Output register counts toward the depth, so at most DEPTH words are held
  assign bus.in_ready  = (bus.level != FULL_CNT);
  assign bus.out_valid = st_ff.out_valid;
  assign bus.out_data  = st_ff.out_data;
  assign bus.level     = st_ff.count + (AW+1)'(st_ff.out_valid);

  always_comb begin
    nxt_st = st_ff;
    push   = bus.in_valid && bus.in_ready;
    load   = (!st_ff.out_valid || bus.out_ready) && (st_ff.count != '0);
    if (push) begin
      nxt_st.mem[st_ff.wptr] = bus.in_data;
      nxt_st.wptr            = st_ff.wptr + 1'b1;
    end
    if (load) begin
      nxt_st.out_data  = st_ff.mem[st_ff.rptr];
      nxt_st.out_valid = 1'b1;
      nxt_st.rptr      = st_ff.rptr + 1'b1;
    end else if (bus.out_ready) begin
      nxt_st.out_valid = 1'b0;
    end
    nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: design/sfsc_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   Only the second stage is visible to other logic
`timescale 1ns/1ns
module sfsc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sfsc_sync_state_s;

  sfsc_sync_state_s st_ff;
  sfsc_sync_state_s nxt_st;

  assign dout = st_ff.stage2;

  always_comb begin
    nxt_st.stage1 = din;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: design/sfsc_top.sv
// Purpose: Serial port control word, frame sync and select pin drive
// Assumes: Peripheral bus clock is clock; reference clock arrives on a pin
// Notes:   Transmit only; characters are eight bits, MSB first
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
//
// Function
// - Framing enable turns select pin into sync
// - Sync direction: 1 input, 0 driven output
// - Sync polarity picks active high or low
// - Auto select drives pin during master transfer
// - Auto select level follows sync polarity
// - Width bit: whole character or one clock
// - Group code: pulse per 1..32 characters
// - Group count ignored outside framed operation
// - Baud source: reference clock or bus clock
// - Control bits 22 to 18 read zero
// - Baud source writable only while port off
// - Audio mode forces idle clock polarity high
module sfsc_top (
  input  wire logic                            clock,
  input  wire logic                            rst_b,
  input  wire logic [3:0]                      addr,
  input  wire logic [31:0]                     wdata,
  input  wire logic                            wr_en,
  input  wire logic                            rd_en,
  output logic      [31:0]                     rdata,
  input  wire logic                            reference_clock,
  output logic                                 sclk_out,
  output logic                                 sdo_out,
  input  wire logic                            ss_in,
  output logic                                 ss_out,
  output logic                                 ss_oe_b
);
  import sfsc_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]           ctrl;
    logic                  audio;
    logic                  overflow;
    logic [31:0]           rdata;
    logic                  busy;
    logic                  phase;
    logic [2:0]            bit_cnt;
    logic [CHAR_BITS-1:0]  shreg;
    logic [GROUP_BITS-1:0] grp_cnt;
    logic                  in_group;
    logic                  pulse_char;
    logic                  ref_prev;
    logic                  sync_prev;
    logic                  sclk;
    logic                  sdo;
    logic                  ss_out;
    logic                  ss_oe_b;
  } sfsc_state_s;

  sfsc_state_s           st_ff;
  sfsc_state_s           nxt_st;
  logic [1:0]            pins_s;
  logic                  ref_s;
  logic                  ss_s;
  logic                  port_on;
  logic                  framed;
  logic                  sync_in;
  logic                  pol;
  logic                  master;
  logic                  idle_lvl;
  logic                  tick;
  logic                  sync_act;
  logic                  sync_edge;
  logic                  start_ok;
  logic [2:0]            grp_code;
  logic [GROUP_BITS-1:0] grp_last;
  logic                  char_end;

  sfsc_fifo_if #(.WIDTH(CHAR_BITS), .DEPTH(FIFO_DEPTH)) txq ();

  sfsc_fifo #(
    .WIDTH (CHAR_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst_b (rst_b),
    .bus   (txq)
  );

  sfsc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({reference_clock, ss_in}),
    .dout  (pins_s)
  );

  assign ref_s = pins_s[1];
  assign ss_s  = pins_s[0];

  // --------------------------------------------------------------------
  // Decoded control
  // --------------------------------------------------------------------
  assign port_on   = st_ff.ctrl[BIT_PORT_ON];
  assign framed    = st_ff.ctrl[BIT_FRAMING];
  assign sync_in   = st_ff.ctrl[BIT_SYNC_DIR];
  assign pol       = st_ff.ctrl[BIT_SYNC_POL];
  assign master    = st_ff.ctrl[BIT_MASTER];
  assign idle_lvl  = st_ff.ctrl[BIT_IDLE_POL] | st_ff.audio;
  assign tick      = st_ff.ctrl[BIT_BAUD_SRC] ? (ref_s & ~st_ff.ref_prev) : 1'b1;
  assign sync_act  = (ss_s == pol);
  assign sync_edge = sync_act & ~st_ff.sync_prev;
  // An incoming sync opens a group; the rest of the group follows it
  assign start_ok  = !framed || !sync_in || st_ff.in_group || sync_edge;
  // Reserved codes are clamped so the counter stays bounded
  assign grp_code  = (st_ff.ctrl[BIT_GROUP_HI:BIT_GROUP_LO] > GROUP_MAX_CODE) ?
                     GROUP_MAX_CODE : st_ff.ctrl[BIT_GROUP_HI:BIT_GROUP_LO];
  assign grp_last  = GROUP_BITS'((6'h01 << grp_code) - 6'h01);
  assign char_end  = st_ff.busy && tick && st_ff.phase && (st_ff.bit_cnt == LAST_BIT);

  assign txq.in_data   = wdata[CHAR_BITS-1:0];
  assign txq.in_valid  = wr_en && (addr == ADDR_DATA);
  assign txq.out_ready = port_on && master && !st_ff.busy && start_ok;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.ref_prev  = ref_s;
    nxt_st.sync_prev = sync_act;

    // Register writes
    if (wr_en) begin
      unique case (addr)
        ADDR_CONTROL: begin
          nxt_st.ctrl = wdata & CTRL_WR_MASK;
          nxt_st.ctrl[BIT_BAUD_SRC] = port_on ? st_ff.ctrl[BIT_BAUD_SRC] :
                                      wdata[BIT_BAUD_SRC];
        end
        ADDR_AUDIO: begin
          nxt_st.audio = wdata[BIT_AUDIO_EN];
        end
        ADDR_STATUS: begin
          if (wdata[ST_OVERFLOW]) begin
            nxt_st.overflow = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if (txq.in_valid && !txq.in_ready) begin
      nxt_st.overflow = 1'b1;
    end

    // Register reads, answer stands one cycle later
    nxt_st.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        ADDR_CONTROL: nxt_st.rdata = st_ff.ctrl & CTRL_RD_MASK;
        ADDR_AUDIO:   nxt_st.rdata[BIT_AUDIO_EN] = st_ff.audio;
        ADDR_STATUS: begin
          nxt_st.rdata[ST_EMPTY]    = (txq.level == '0);
          nxt_st.rdata[ST_FULL]     = !txq.in_ready;
          nxt_st.rdata[ST_LEVEL_LO +: LEVEL_BITS] = txq.level;
          nxt_st.rdata[ST_GROUP_LO +: GROUP_BITS] = st_ff.grp_cnt;
          nxt_st.rdata[ST_BUSY]     = st_ff.busy;
          nxt_st.rdata[ST_OVERFLOW] = st_ff.overflow;
        end
        default:      nxt_st.rdata = '0;
      endcase
    end

    // Shift engine
    if (txq.out_ready && txq.out_valid) begin
      nxt_st.busy       = 1'b1;
      nxt_st.phase      = 1'b0;
      nxt_st.bit_cnt    = '0;
      nxt_st.shreg      = txq.out_data;
      nxt_st.sdo        = txq.out_data[CHAR_BITS-1];
      nxt_st.pulse_char = framed && !sync_in && (st_ff.grp_cnt == '0);
    end else if (st_ff.busy && tick) begin
      nxt_st.phase = !st_ff.phase;
      if (st_ff.phase) begin
        if (st_ff.bit_cnt == LAST_BIT) begin
          nxt_st.busy = 1'b0;
        end else begin
          nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
          nxt_st.shreg   = {st_ff.shreg[CHAR_BITS-2:0], 1'b0};
          nxt_st.sdo     = st_ff.shreg[CHAR_BITS-2];
        end
      end
    end

    // Frame group counter
    if (char_end) begin
      nxt_st.grp_cnt  = (st_ff.grp_cnt == grp_last) ? '0 :
                        st_ff.grp_cnt + GROUP_BITS'(1);
      nxt_st.in_group = sync_in && (st_ff.grp_cnt != grp_last);
    end else if (sync_edge && sync_in) begin
      nxt_st.in_group = 1'b1;
    end
    if (!port_on || !framed) begin
      nxt_st.grp_cnt  = '0;
      nxt_st.in_group = 1'b0;
    end
    if (!port_on) begin
      nxt_st.busy  = 1'b0;
      nxt_st.phase = 1'b0;
    end

    // Pin drive from the next state, so outputs stay registered
    nxt_st.sclk = idle_lvl ^ (nxt_st.busy && nxt_st.phase);
    nxt_st.ss_out  = 1'b0;
    nxt_st.ss_oe_b = 1'b1;
    if (port_on && framed && !sync_in) begin
      nxt_st.ss_oe_b = 1'b0;
      nxt_st.ss_out  = (nxt_st.busy && nxt_st.pulse_char &&
                        (st_ff.ctrl[BIT_SYNC_WIDTH] || nxt_st.bit_cnt == '0)) ?
                       pol : !pol;
    end else if (port_on && !framed && master && st_ff.ctrl[BIT_AUTO_SEL]) begin
      nxt_st.ss_oe_b = 1'b0;
      nxt_st.ss_out  = nxt_st.busy ? pol : !pol;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff         <= '0;
      st_ff.ctrl    <= CTRL_RESET;
      st_ff.sclk    <= 1'b0;
      st_ff.ss_oe_b <= 1'b1;
      // No false sync edge while the synchroniser fills after reset
      st_ff.sync_prev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata    = st_ff.rdata;
  assign sclk_out = st_ff.sclk;
  assign sdo_out  = st_ff.sdo;
  assign ss_out   = st_ff.ss_out;
  assign ss_oe_b  = st_ff.ss_oe_b;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_no_sync_drive;
    @(posedge clock) disable iff (!rst_b)
    (!framed && !st_ff.ctrl[BIT_AUTO_SEL]) |=> ss_oe_b;
  endproperty
  a_no_sync_drive: assert property (p_no_sync_drive)
    else $error("select pin driven with framing and auto select off");

  property p_sync_dir;
    @(posedge clock) disable iff (!rst_b)
    (port_on && framed) |=> (ss_oe_b == $past(sync_in));
  endproperty
  a_sync_dir: assert property (p_sync_dir)
    else $error("frame sync drive does not follow direction");

  property p_auto_level;
    @(posedge clock) disable iff (!rst_b)
    (port_on && !framed && master && st_ff.ctrl[BIT_AUTO_SEL] && !wr_en &&
     !$past(wr_en) && st_ff.busy) |-> (!ss_oe_b && ss_out == pol);
  endproperty
  a_auto_level: assert property (p_auto_level)
    else $error("auto select not at polarity level during transfer");

  property p_wide_pulse;
    @(posedge clock) disable iff (!rst_b)
    (port_on && framed && !sync_in && st_ff.ctrl[BIT_SYNC_WIDTH] && !wr_en &&
     !$past(wr_en) && st_ff.busy && st_ff.pulse_char) |-> (ss_out == pol);
  endproperty
  a_wide_pulse: assert property (p_wide_pulse)
    else $error("wide frame pulse dropped inside character");

  property p_group_first;
    @(posedge clock) disable iff (!rst_b)
    (txq.out_ready && txq.out_valid && framed && !sync_in && port_on) |=>
    (st_ff.pulse_char == ($past(st_ff.grp_cnt) == '0));
  endproperty
  a_group_first: assert property (p_group_first)
    else $error("frame pulse not on first character of group");

  property p_group_idle;
    @(posedge clock) disable iff (!rst_b)
    (!framed) |=> (st_ff.grp_cnt == '0);
  endproperty
  a_group_idle: assert property (p_group_idle)
    else $error("group counter moved outside framed operation");

  property p_baud_hold;
    @(posedge clock) disable iff (!rst_b)
    (port_on && st_ff.busy && st_ff.ctrl[BIT_BAUD_SRC] && !(ref_s && !st_ff.ref_prev))
    |=> (st_ff.phase == $past(st_ff.phase));
  endproperty
  a_baud_hold: assert property (p_baud_hold)
    else $error("shift advanced without reference clock edge");

  property p_reserved_zero;
    @(posedge clock) disable iff (!rst_b)
    (rd_en && addr == ADDR_CONTROL) |=> (rdata[22:18] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented control bits read nonzero");

  property p_baud_lock;
    @(posedge clock) disable iff (!rst_b)
    (wr_en && addr == ADDR_CONTROL && port_on) |=>
    (st_ff.ctrl[BIT_BAUD_SRC] == $past(st_ff.ctrl[BIT_BAUD_SRC]));
  endproperty
  a_baud_lock: assert property (p_baud_lock)
    else $error("baud source changed while port on");

  property p_audio_idle;
    @(posedge clock) disable iff (!rst_b)
    (st_ff.audio && !st_ff.busy && $past(st_ff.audio) && !wr_en && !$past(wr_en))
    |-> sclk_out;
  endproperty
  a_audio_idle: assert property (p_audio_idle)
    else $error("idle clock low while audio mode enabled");
endmodule

// file: dv/sfsc_peer.sv
// Purpose: Serial peer that takes characters and frame pulses off the pins
// Assumes: Data bit is settled at the leading sclk edge, MSB first
// Notes:   Select pin is pulled high when nobody drives it
`timescale 1ns/1ns
module sfsc_peer (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       sclk,
  input  wire logic       sdo,
  input  wire logic       ss_out,
  input  wire logic       ss_oe_b,
  input  wire logic       idle,
  input  wire logic       pol,
  input  wire logic       drive,
  input  wire logic       fire,
  output logic            ss_in,
  output int              n_bytes,
  output logic [7:0]      last_byte,
  output int              n_pulse,
  output int              pulse_w,
  output int              n_stray
);
  logic       sclk_q;
  logic [7:0] shreg;
  int         nbit;
  int         cur_w;
  logic       act;

  // --------------------------------------------------------------------
  // Pin level and capture
  // --------------------------------------------------------------------
  // In slave role the peer owns the sync line and rests it inactive
  assign ss_in = !ss_oe_b ? ss_out : (drive ? (fire ? pol : !pol) : 1'b1);
  assign act   = !ss_oe_b && (ss_out == pol);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q    <= 1'b0;
      shreg     <= 8'h00;
      nbit      <= 0;
      cur_w     <= 0;
      n_bytes   <= 0;
      last_byte <= 8'h00;
      n_pulse   <= 0;
      pulse_w   <= 0;
      n_stray   <= 0;
    end else begin
      sclk_q <= sclk;
      if (sclk != sclk_q && sclk != idle) begin
        shreg <= {shreg[6:0], sdo};
        if (!act) n_stray <= n_stray + 1;
        if (nbit == 7) begin
          nbit      <= 0;
          n_bytes   <= n_bytes + 1;
          last_byte <= {shreg[6:0], sdo};
        end else begin
          nbit <= nbit + 1;
        end
      end
      if (act) begin
        cur_w <= cur_w + 1;
      end else if (cur_w != 0) begin
        pulse_w <= cur_w;
        n_pulse <= n_pulse + 1;
        cur_w   <= 0;
      end
    end
  end
endmodule

// file: dv/sfsc_top_tb.sv
// Purpose: Self-checking bench of the frame sync control block
// Assumes: Bus clock baud source unless a test selects the reference clock
// Notes:   Peer counters are compared as deltas across each test
`timescale 1ns/1ns
module sfsc_top_tb;
  import sfsc_pkg::*;
  localparam int          LIMIT = 40000;
  localparam logic [31:0] F_FRM = 32'h8000_0000;
  localparam logic [31:0] F_DIR = 32'h4000_0000;
  localparam logic [31:0] F_POL = 32'h2000_0000;
  localparam logic [31:0] F_AUT = 32'h1000_0000;
  localparam logic [31:0] F_WID = 32'h0800_0000;
  localparam logic [31:0] F_BAU = 32'h0080_0000;
  localparam logic [31:0] F_RUN = 32'h0000_8020;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic        reference_clock = 1'b0;
  logic        sclk_out, sdo_out, ss_in, ss_out, ss_oe_b;
  logic        idle = 1'b0;
  logic        pol = 1'b0;
  logic        drive = 1'b0;
  logic        fire = 1'b0;
  logic [7:0]  last_byte;
  int          n_bytes, n_pulse, pulse_w, n_stray;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;

  sfsc_top i_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .reference_clock(reference_clock), .sclk_out(sclk_out),
    .sdo_out(sdo_out), .ss_in(ss_in), .ss_out(ss_out), .ss_oe_b(ss_oe_b));
  sfsc_peer i_peer (.clock(clock), .rst_b(rst_b), .sclk(sclk_out), .sdo(sdo_out),
    .ss_out(ss_out), .ss_oe_b(ss_oe_b), .idle(idle), .pol(pol), .drive(drive), .fire(fire),
    .ss_in(ss_in), .n_bytes(n_bytes), .last_byte(last_byte), .n_pulse(n_pulse),
    .pulse_w(pulse_w), .n_stray(n_stray));

  always #20 clock = ~clock;
  always #60 reference_clock = ~reference_clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  // --------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic push(input int n, input logic [7:0] base);
    logic [31:0] s;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 200; k++) begin
        rd(ADDR_STATUS, s);
        if (!s[ST_FULL]) break;
      end
      wr(ADDR_DATA, {24'h0, base + 8'(i)});
    end
  endtask
  task automatic drain();
    logic [31:0] s;
    int          quiet;
    quiet = 0;
    for (int k = 0; k < 3000 && quiet < 2; k++) begin
      rd(ADDR_STATUS, s);
      quiet = (s[ST_EMPTY] && !s[ST_BUSY]) ? quiet + 1 : 0;
    end
    repeat (4) @(posedge clock);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd(ADDR_CONTROL, d);
    chk(d, CTRL_RESET);
    // Idle bit below moves the clock rest level; the peer must not see a bit
    idle = 1'b1;
    wr(ADDR_CONTROL, 32'hFFFF_FFFF);
    rd(ADDR_CONTROL, d);
    chk(d, CTRL_RD_MASK);
    @(posedge clock);
    #1 chk(rdata, 32'h0);
    wr(ADDR_CONTROL, 32'h0);
    idle = 1'b0;
    rd(ADDR_CONTROL, d);
    chk(d, F_BAU);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, d);
    chk(d, 32'h0);
    wr(ADDR_CONTROL, 32'h0);
    rd(ADDR_CONTROL, d);
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_fifo();
    logic [31:0] s;
    int          b0, s0;
    b0 = n_bytes;
    s0 = n_stray;
    for (int i = 0; i < 17; i++) wr(ADDR_DATA, i);
    rd(ADDR_STATUS, s);
    chk(s & 32'h0002_007F, 32'h0002_0042);
    wr(ADDR_STATUS, 32'h0002_0000);
    rd(ADDR_STATUS, s);
    chk(s & 32'h0002_007F, 32'h0000_0042);
    wr(ADDR_CONTROL, F_RUN);
    drain();
    rd(ADDR_STATUS, s);
    chk(s & 32'h0002_007F, 32'h0000_0001);
    chk(n_bytes - b0, 16);
    chk(last_byte, 8'h0F);
    chk(n_stray - s0, 128);
    $display("test fifo done");
  endtask
  task automatic t_auto();
    int p0, s0;
    wr(ADDR_CONTROL, 32'h0);
    pol = 1'b0;
    p0 = n_pulse;
    s0 = n_stray;
    wr(ADDR_CONTROL, F_AUT | 32'h0500_0000 | F_RUN);
    push(3, 8'hC0);
    drain();
    chk(n_pulse - p0, 3);
    chk(n_stray - s0, 0);
    chk(last_byte, 8'hC2);
    $display("test auto select done");
  endtask
  task automatic t_group();
    logic [2:0] c;
    int         p0, b0, n;
    for (int code = 0; code < 6; code++) begin
      c = code[2:0];
      wr(ADDR_CONTROL, 32'h0);
      // Let the pin release before the polarity changes
      repeat (2) @(posedge clock);
      pol = c[0];
      p0 = n_pulse;
      b0 = n_bytes;
      n = 2 << code;
      wr(ADDR_CONTROL, F_FRM | (c[0] ? F_POL : 0) | (c[1] ? F_WID : 0) | {5'h0, c, 24'h0}
        | F_RUN);
      push(n, 8'h40);
      drain();
      chk(n_pulse - p0, 2);
      chk(n_bytes - b0, n);
      chk(last_byte, 8'h40 + 8'(n - 1));
      if (c[1]) chk(pulse_w >= 15 && pulse_w <= 16, 1);
      else chk(pulse_w, 2);
      chk({ss_oe_b, ss_out}, {1'b0, !pol});
    end
    $display("test group done");
  endtask
  task automatic t_slave();
    int b0;
    wr(ADDR_CONTROL, 32'h0);
    pol = 1'b1;
    drive = 1'b1;
    b0 = n_bytes;
    wr(ADDR_CONTROL, F_FRM | F_DIR | F_POL | F_RUN);
    push(1, 8'hA5);
    repeat (40) @(posedge clock);
    chk(n_bytes - b0, 0);
    chk(ss_oe_b, 1'b1);
    fire <= 1'b1;
    repeat (4) @(posedge clock);
    fire <= 1'b0;
    drain();
    chk(n_bytes - b0, 1);
    chk(last_byte, 8'hA5);
    wr(ADDR_CONTROL, 32'h0);
    drive = 1'b0;
    $display("test slave sync done");
  endtask
  task automatic t_audio_baud();
    int t0;
    idle = 1'b1;
    wr(ADDR_AUDIO, 32'h1);
    wr(ADDR_CONTROL, F_RUN);
    repeat (3) @(posedge clock);
    chk(sclk_out, 1'b1);
    push(1, 8'h3C);
    drain();
    chk(last_byte, 8'h3C);
    idle = 1'b0;
    wr(ADDR_AUDIO, 32'h0);
    wr(ADDR_CONTROL, 32'h0);
    repeat (3) @(posedge clock);
    chk(sclk_out, 1'b0);
    wr(ADDR_CONTROL, F_BAU);
    wr(ADDR_CONTROL, F_BAU | F_RUN);
    t0 = cyc;
    push(1, 8'h5A);
    drain();
    chk(last_byte, 8'h5A);
    chk(cyc - t0 > 45, 1);
    wr(ADDR_CONTROL, F_BAU);
    wr(ADDR_CONTROL, 32'h0);
    $display("test audio and baud done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_fifo();
    t_auto();
    t_group();
    t_slave();
    t_audio_baud();
    final_report();
  end
endmodule
